// ### design/interval_timer_rtc.sv
// Purpose: Interval timer with real-time clock timebase
// Assumes: Crystal pin is asynchronous; warm reset is on clk_sys
// Notes:   Register reads answer one cycle after the read strobe
//
// How it works
// - Timebase field picks fraction, seconds, minutes or hours ticks.
// - Single-shot mode clears the counter enable at a timeout.
// - Periodic mode reloads the counter at each timeout and keeps counting.
// - Match flag sets when a tick would bring the interval count to the compare value.
// - Counter enable runs the counter; low stops and zeroes it.
// - Clock enable passes crystal edges to prescaler and counters.
// - Clock enable low stops the chain and zeroes prescaler and times.
// - Time register writes only take effect while clock enable is low.
// - Compare register holds an 8-bit value from 0 to 255.
// - Match flag is bit 2 and raises the interrupt when enabled.
// - Sub-second counts 0 to 127 each 1/128 s, carrying into seconds.
// - Sub-second zero at power-on; warm reset keeps it if clock enabled.
// - Seconds count 0 to 59 then carry into minutes.
// - Minutes count 0 to 59 then carry into hours.
// - Hours count 0 to 23 then wrap to zero.
// - Interval counter advances on each carry into the selected register.
`timescale 1ns/1ps
module interval_timer_rtc
(
  // Clock and resets
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       warm_resetn,
  // Crystal pin
  input  wire logic       xtal_32k,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Interrupt side
  input  wire logic       interval_irq_enable,
  output logic            interval_irq,
  output logic            interval_timeout,
  output logic            time_running
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rtc_time_if tb ();

  logic       xtal_meta;
  logic       xtal_sync;
  logic       xtal_last;
  logic       xtal_tick;

  logic       time_clock_enable;
  logic       interval_counter_enable;
  logic       interval_match_flag;
  logic       single_shot_select;
  logic [1:0] timebase_select;
  logic       reserved_one;

  logic [7:0] interval_compare_value;
  logic [7:0] time_interval_counter;
  logic       time_clear_pending;

  logic       ctl_write;
  logic       cmp_write;
  logic       time_write;
  logic       tb_tick;
  logic       timeout;
  logic       warm;
  logic [7:0] control_view;
  logic [7:0] next_rdata;

  // Register hit on a given offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Crystal pin synchroniser
  // ----------------------------------------------------------------

  // Two flops before use; edge detect compares the second with a third
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_last <= 1'b0;
    end
    else
    begin
      xtal_meta <= xtal_32k;
      xtal_sync <= xtal_meta;
      xtal_last <= xtal_sync;
    end
  end

  // One strobe per crystal rising edge
  assign xtal_tick = xtal_sync && !xtal_last;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------

  // Warm reset is synchronous and level, same domain
  assign warm      = !warm_resetn;
  assign ctl_write = reg_write && hit(reg_addr, rtc_pkg::ADDR_CONTROL);
  assign cmp_write = reg_write && hit(reg_addr, rtc_pkg::ADDR_INTERVAL);

  // Time writes are dropped while the clock runs
  assign time_write = reg_write && !time_clock_enable && !warm &&
                      (hit(reg_addr, rtc_pkg::ADDR_SUB_SEC) ||
                       hit(reg_addr, rtc_pkg::ADDR_SECONDS) ||
                       hit(reg_addr, rtc_pkg::ADDR_MINUTES) ||
                       hit(reg_addr, rtc_pkg::ADDR_HOURS));

  // ----------------------------------------------------------------
  // Time chain hookup
  // ----------------------------------------------------------------

  // Target follows the address order of the four time registers
  always_comb
  begin
    tb.wr_target = rtc_pkg::TB_FRACTION;
    unique case (reg_addr)
      rtc_pkg::ADDR_SECONDS: tb.wr_target = rtc_pkg::TB_SECONDS;
      rtc_pkg::ADDR_MINUTES: tb.wr_target = rtc_pkg::TB_MINUTES;
      rtc_pkg::ADDR_HOURS:   tb.wr_target = rtc_pkg::TB_HOURS;
      default:               tb.wr_target = rtc_pkg::TB_FRACTION;
    endcase
  end

  assign tb.xtal_tick = xtal_tick;
  assign tb.run       = time_clock_enable;
  assign tb.wr_en     = time_write;
  assign tb.wr_data   = reg_wdata;

  // Clear lands on a crystal edge, or at once on a warm reset
  // with the clock stopped; a running clock survives warm reset
  assign tb.clear = !time_clock_enable &&
                    ((time_clear_pending && xtal_tick) || warm);

  time_chain u_time_chain
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tb      (tb.counter)
  );

  // ----------------------------------------------------------------
  // Clear sequencing after clock enable drops
  // ----------------------------------------------------------------

  // Armed by the falling enable, spent at the next crystal edge;
  // re-enabling first leaves the times untouched
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      time_clear_pending <= 1'b0;
    else if (time_clock_enable && ctl_write &&
             !reg_wdata[rtc_pkg::CTL_CLOCK_EN])
      time_clear_pending <= 1'b1;
    else if (time_clock_enable || xtal_tick)
      time_clear_pending <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // Clock enable survives warm reset so the clock keeps time
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      time_clock_enable <= 1'b0;
    else if (ctl_write && !warm)
      time_clock_enable <= reg_wdata[rtc_pkg::CTL_CLOCK_EN];
  end

  // Mode fields; the reserved bit is stored as written
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      single_shot_select <= 1'b0;
      timebase_select    <= 2'h0;
      reserved_one       <= 1'b0;
    end
    else if (warm)
    begin
      single_shot_select <= 1'b0;
      timebase_select    <= 2'h0;
      reserved_one       <= 1'b0;
    end
    else if (ctl_write)
    begin
      single_shot_select <= reg_wdata[rtc_pkg::CTL_SINGLE];
      timebase_select    <= reg_wdata[rtc_pkg::CTL_TB_HIGH:rtc_pkg::CTL_TB_LOW];
      reserved_one       <= reg_wdata[rtc_pkg::CTL_RESV_ONE];
    end
  end

  // Counter enable; a software write beats the single-shot clear
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      interval_counter_enable <= 1'b0;
    else if (warm)
      interval_counter_enable <= 1'b0;
    else if (ctl_write)
      interval_counter_enable <= reg_wdata[rtc_pkg::CTL_COUNT_EN];
    else if (timeout && single_shot_select)
      interval_counter_enable <= 1'b0;
  end

  // Match flag; a timeout in the clearing cycle still sets it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      interval_match_flag <= 1'b0;
    else if (warm)
      interval_match_flag <= 1'b0;
    else if (timeout)
      interval_match_flag <= 1'b1;
    else if (ctl_write)
      interval_match_flag <= reg_wdata[rtc_pkg::CTL_MATCH];
  end

  // ----------------------------------------------------------------
  // Compare register
  // ----------------------------------------------------------------

  // Full byte range; zero means 256 ticks per interval
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      interval_compare_value <= rtc_pkg::ZERO_BYTE;
    else if (warm)
      interval_compare_value <= rtc_pkg::ZERO_BYTE;
    else if (cmp_write)
      interval_compare_value <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------

  // Timebase picks which overflow advances the counter
  always_comb
  begin
    tb_tick = 1'b0;
    unique case (rtc_pkg::timebase_t'(timebase_select))
      rtc_pkg::TB_FRACTION: tb_tick = tb.fraction_tick;
      rtc_pkg::TB_SECONDS:  tb_tick = tb.second_tick;
      rtc_pkg::TB_MINUTES:  tb_tick = tb.minute_tick;
      rtc_pkg::TB_HOURS:    tb_tick = tb.hour_tick;
    endcase
  end

  // Timeout when the advanced count reaches the compare value
  assign timeout = interval_counter_enable && tb_tick &&
                   ((time_interval_counter + rtc_pkg::ONE_BYTE) ==
                    interval_compare_value);

  // Counter; zeroing with the enable low waits for a crystal edge,
  // which is why software must hold the enable low one period
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      time_interval_counter <= rtc_pkg::ZERO_BYTE;
    else if (warm)
      time_interval_counter <= rtc_pkg::ZERO_BYTE;
    else if (!interval_counter_enable)
    begin
      if (xtal_tick)
        time_interval_counter <= rtc_pkg::ZERO_BYTE;
    end
    else if (timeout)
      time_interval_counter <= rtc_pkg::ZERO_BYTE;
    else if (tb_tick)
      time_interval_counter <= time_interval_counter + rtc_pkg::ONE_BYTE;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Request follows the flag one cycle later, gated by the enable
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      interval_irq <= 1'b0;
    else
      interval_irq <= interval_match_flag && interval_irq_enable;
  end

  // Timeout strobe for the wakeup path
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      interval_timeout <= 1'b0;
    else
      interval_timeout <= timeout;
  end

  // Running level mirrors clock enable
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      time_running <= 1'b0;
    else
      time_running <= time_clock_enable;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Top bit reads zero
  assign control_view = {1'b0, reserved_one, timebase_select,
                         single_shot_select, interval_match_flag,
                         interval_counter_enable, time_clock_enable};

  // Unmapped offsets read zero; reads change nothing
  always_comb
  begin
    next_rdata = rtc_pkg::ZERO_BYTE;
    if (reg_read)
    begin
      unique case (reg_addr)
        rtc_pkg::ADDR_CONTROL:   next_rdata = control_view;
        rtc_pkg::ADDR_SUB_SEC:   next_rdata = tb.sub_sec;
        rtc_pkg::ADDR_SECONDS:   next_rdata = tb.seconds;
        rtc_pkg::ADDR_MINUTES:   next_rdata = tb.minutes;
        rtc_pkg::ADDR_HOURS:     next_rdata = tb.hours;
        rtc_pkg::ADDR_INTERVAL:  next_rdata = interval_compare_value;
        rtc_pkg::ADDR_INT_COUNT: next_rdata = time_interval_counter;
        default:                 next_rdata = rtc_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= rtc_pkg::ZERO_BYTE;
    else
      reg_rdata <= next_rdata;
  end

endmodule : interval_timer_rtc

// ### design/rtc_pkg.sv
// Purpose: Shared constants and types for the interval timer and clock
// Assumes: 8-bit register port, 50 MHz system clock, 32.768 kHz crystal
// Notes:   Offsets are byte addresses on the register port
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL   = 8'hA1;
  localparam logic [7:0] ADDR_SUB_SEC   = 8'hA2;
  localparam logic [7:0] ADDR_SECONDS   = 8'hA3;
  localparam logic [7:0] ADDR_MINUTES   = 8'hA4;
  localparam logic [7:0] ADDR_HOURS     = 8'hA5;
  localparam logic [7:0] ADDR_INTERVAL  = 8'hA6;
  localparam logic [7:0] ADDR_INT_COUNT = 8'hA7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_CLOCK_EN  = 0;
  localparam int CTL_COUNT_EN  = 1;
  localparam int CTL_MATCH     = 2;
  localparam int CTL_SINGLE    = 3;
  localparam int CTL_TB_LOW    = 4;
  localparam int CTL_TB_HIGH   = 5;
  localparam int CTL_RESV_ONE  = 6;

  // ----------------------------------------------------------------
  // Reset values and count limits
  // ----------------------------------------------------------------
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] ONE_BYTE      = 8'h01;
  localparam logic [7:0] PRESCALE_LAST = 8'hFF;
  localparam logic [7:0] SUB_SEC_LAST  = 8'h7F;
  localparam logic [7:0] SECONDS_LAST  = 8'h3B;
  localparam logic [7:0] MINUTES_LAST  = 8'h3B;
  localparam logic [7:0] HOURS_LAST    = 8'h17;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int XTAL_HZ           = 32768;
  localparam int CLK_PERIOD_NS     = 20;
  localparam int CLEAR_HOLD_NS     = 30500;
  localparam int CLEAR_HOLD_CYCLES =
    (CLEAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Timebase select, codes in select order
  typedef enum logic [1:0] {
    TB_FRACTION,
    TB_SECONDS,
    TB_MINUTES,
    TB_HOURS
  } timebase_t;

endpackage : rtc_pkg

// ### design/rtc_time_if.sv
// Purpose: Carrier between control logic and the time counter chain
// Assumes: One clock domain, clk_sys
// Notes:   Ticks are single-cycle strobes
`timescale 1ns/1ps
interface rtc_time_if;
  logic              xtal_tick;
  logic              run;
  logic              clear;
  logic              wr_en;
  rtc_pkg::timebase_t wr_target;
  logic [7:0]        wr_data;
  logic [7:0]        sub_sec;
  logic [7:0]        seconds;
  logic [7:0]        minutes;
  logic [7:0]        hours;
  logic              fraction_tick;
  logic              second_tick;
  logic              minute_tick;
  logic              hour_tick;

  modport ctrl (output xtal_tick, run, clear, wr_en, wr_target, wr_data,
                input sub_sec, seconds, minutes, hours,
                fraction_tick, second_tick, minute_tick, hour_tick);
  modport counter (input xtal_tick, run, clear, wr_en, wr_target, wr_data,
                   output sub_sec, seconds, minutes, hours,
                   fraction_tick, second_tick, minute_tick, hour_tick);
endinterface : rtc_time_if

// ### design/time_chain.sv
// Purpose: Prescaler and sub-second, seconds, minutes, hours counters
// Assumes: Caller gates writes to times when the clock is stopped
// Notes:   Values above a limit wrap on the next tick
`timescale 1ns/1ps
module time_chain
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Control side
  rtc_time_if.counter tb
);

  logic [7:0] prescale;

  // True when a counter sits at or past its last legal value
  function automatic logic at_last(input logic [7:0] v, input logic [7:0] last);
    at_last = (v >= last);
  endfunction : at_last

  // Carry chain
  assign tb.fraction_tick = tb.run && tb.xtal_tick &&
                            (prescale == rtc_pkg::PRESCALE_LAST);
  assign tb.second_tick = tb.fraction_tick &&
                          at_last(tb.sub_sec, rtc_pkg::SUB_SEC_LAST);
  assign tb.minute_tick = tb.second_tick &&
                          at_last(tb.seconds, rtc_pkg::SECONDS_LAST);
  assign tb.hour_tick = tb.minute_tick &&
                        at_last(tb.minutes, rtc_pkg::MINUTES_LAST);

  // Prescaler, divides crystal edges by 256
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      prescale <= rtc_pkg::ZERO_BYTE;
    else if (tb.clear)
      prescale <= rtc_pkg::ZERO_BYTE;
    else if (tb.run && tb.xtal_tick)
      prescale <= prescale + rtc_pkg::ONE_BYTE;
  end

  // Sub-second counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tb.sub_sec <= rtc_pkg::ZERO_BYTE;
    else if (tb.clear)
      tb.sub_sec <= rtc_pkg::ZERO_BYTE;
    else if (tb.wr_en && tb.wr_target == rtc_pkg::TB_FRACTION)
      tb.sub_sec <= tb.wr_data;
    else if (tb.fraction_tick)
      tb.sub_sec <= tb.second_tick ? rtc_pkg::ZERO_BYTE
                                   : tb.sub_sec + rtc_pkg::ONE_BYTE;
  end

  // Seconds counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tb.seconds <= rtc_pkg::ZERO_BYTE;
    else if (tb.clear)
      tb.seconds <= rtc_pkg::ZERO_BYTE;
    else if (tb.wr_en && tb.wr_target == rtc_pkg::TB_SECONDS)
      tb.seconds <= tb.wr_data;
    else if (tb.second_tick)
      tb.seconds <= tb.minute_tick ? rtc_pkg::ZERO_BYTE
                                   : tb.seconds + rtc_pkg::ONE_BYTE;
  end

  // Minutes counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tb.minutes <= rtc_pkg::ZERO_BYTE;
    else if (tb.clear)
      tb.minutes <= rtc_pkg::ZERO_BYTE;
    else if (tb.wr_en && tb.wr_target == rtc_pkg::TB_MINUTES)
      tb.minutes <= tb.wr_data;
    else if (tb.minute_tick)
      tb.minutes <= tb.hour_tick ? rtc_pkg::ZERO_BYTE
                                 : tb.minutes + rtc_pkg::ONE_BYTE;
  end

  // Hours counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tb.hours <= rtc_pkg::ZERO_BYTE;
    else if (tb.clear)
      tb.hours <= rtc_pkg::ZERO_BYTE;
    else if (tb.wr_en && tb.wr_target == rtc_pkg::TB_HOURS)
      tb.hours <= tb.wr_data;
    else if (tb.hour_tick)
      tb.hours <= at_last(tb.hours, rtc_pkg::HOURS_LAST) ? rtc_pkg::ZERO_BYTE
                                 : tb.hours + rtc_pkg::ONE_BYTE;
  end

endmodule : time_chain

// ### sim/interval_timer_rtc_properties.sv
// Purpose: Port properties of the interval timer and clock
// Assumes: Sees only the top module's ports
// Notes:   Keeps a mirror of the compare register
`timescale 1ns/1ps
module interval_timer_rtc_checker
(
  // Clock and resets
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       warm_resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Interrupt side
  input wire logic       interval_irq_enable,
  input wire logic       interval_irq,
  input wire logic       interval_timeout,
  input wire logic       time_running
);
  // --------
  // Helpers
  // --------
  logic [7:0] cmp_mirror;
  logic [7:0] rd_sel;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Address read last cycle, 00 when none
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      rd_sel <= 8'h00;
    else
      rd_sel <= reg_read ? reg_addr : 8'h00;

  // Compare mirror; warm reset zeroes it too
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      cmp_mirror <= 8'h00;
    else if (!warm_resetn)
      cmp_mirror <= 8'h00;
    else if (reg_write && reg_addr == 8'hA6)
      cmp_mirror <= reg_wdata;

  // --------
  // Properties
  // --------
  property p_cmp_read;
    rd_sel == 8'hA6 |-> reg_rdata == cmp_mirror;
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("compare readback");
  property p_sub_range;
    rd_sel == 8'hA2 |-> reg_rdata <= rtc_pkg::SUB_SEC_LAST;
  endproperty
  a_sub_range: assert property (p_sub_range) else $error("sub-second range");
  property p_hour_range;
    rd_sel == 8'hA5 |-> reg_rdata <= rtc_pkg::HOURS_LAST;
  endproperty
  a_hour_range: assert property (p_hour_range) else $error("hours range");
  property p_running;
    reg_write && warm_resetn && reg_addr == rtc_pkg::ADDR_CONTROL
      |=> ##1 time_running == $past(reg_wdata[0], 2);
  endproperty
  a_running: assert property (p_running) else $error("clock enable copy");
  property p_match_irq;
    interval_timeout && interval_irq_enable |-> ##[0:2] interval_irq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("no irq on match");
  property p_irq_gate;
    interval_irq |-> $past(interval_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
  property p_sticky;
    interval_irq && interval_irq_enable && !$past(reg_write) && $past(warm_resetn)
      |=> interval_irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped alone");
  property p_tick_gate;
    interval_timeout |-> time_running;
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("timeout while stopped");

  // Main scenarios reached
  c_timeout: cover property (interval_timeout);
  c_irq: cover property (interval_irq);
  c_wrap: cover property (rd_sel == 8'hA5 && reg_rdata == 8'h00);
endmodule : interval_timer_rtc_checker

bind interval_timer_rtc interval_timer_rtc_checker u_interval_timer_rtc_checker (
  .clk_sys(clk_sys), .resetn(resetn), .warm_resetn(warm_resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .interval_irq_enable(interval_irq_enable), .interval_irq(interval_irq),
  .interval_timeout(interval_timeout), .time_running(time_running)
);

// ### sim/interval_timer_rtc_test.sv
// Purpose: Self-checking bench for the interval timer and clock
// Assumes: Crystal pin runs at 8 clk_sys cycles a period
// Notes:   Fast crystal brings a sub-second tick near 2048 cycles
`timescale 1ns/1ps
module interval_timer_rtc_test;
  // --------
  // Signals
  // --------
  localparam int TICK = 2088; // 256 crystal edges plus sync slack
  logic       clk_sys     = 1'b0;
  logic       resetn      = 1'b0;
  logic       warm_resetn = 1'b1;
  logic       irq_en      = 1'b0;
  logic       reg_write   = 1'b0;
  logic       reg_read    = 1'b0;
  logic [7:0] reg_addr    = 8'h00;
  logic [7:0] reg_wdata   = 8'h00;
  logic [2:0] xdiv        = 3'h0;
  logic [7:0] reg_rdata;
  logic       interval_irq;
  logic       time_running;
  logic       interval_timeout;
  logic [7:0] timeouts    = 8'h00;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  // Clock; a real-rate crystal would make the run far too long
  always #10 clk_sys = ~clk_sys;

  // Crystal divider and hang guard
  always @(posedge clk_sys)
  begin
    xdiv <= xdiv + 3'h1;
    // Timeout pulses seen, for the single-shot count
    if (interval_timeout)
      timeouts <= timeouts + 8'h01;
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      end_sim();
    end
  end

  interval_timer_rtc u_interval_timer_rtc (
    .clk_sys(clk_sys), .resetn(resetn), .warm_resetn(warm_resetn),
    .xtal_32k(xdiv[2]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .interval_irq_enable(irq_en), .interval_irq(interval_irq),
    .interval_timeout(interval_timeout), .time_running(time_running)
  );

  // --------
  // Bus tasks
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // Data is looked at only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rc

  task automatic ctl(input logic [7:0] d);
    wr(rtc_pkg::ADDR_CONTROL, d);
  endtask : ctl

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  task automatic warm;
    @(posedge clk_sys);
    warm_resetn <= 1'b0;
    @(posedge clk_sys);
    warm_resetn <= 1'b1;
  endtask : warm

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // --------
  // Scenarios
  // --------
  task automatic s_reset;
    rc(8'hA2, 8'h00);
    rc(8'hA6, 8'h00);
    rc(rtc_pkg::ADDR_CONTROL, 8'h00);
    rc(8'hB0, 8'h00);
  endtask : s_reset

  // Stop arms a clear; warm reset with clock off zeroes times
  task automatic s_clear;
    wr(8'hA2, 8'h05);
    ctl(8'h41);
    rc(8'hA2, 8'h05);
    ctl(8'h40);
    hold(20);
    rc(8'hA2, 8'h00);
    wr(8'hA2, 8'h10);
    warm();
    rc(8'hA2, 8'h00);
  endtask : s_clear

  // Full carry from sub-second to hours, warm reset while running
  task automatic s_roll;
    wr(8'hA2, 8'h7E);
    wr(8'hA3, 8'h3B);
    wr(8'hA4, 8'h3B);
    wr(8'hA5, 8'h17);
    ctl(8'h41);
    wr(8'hA3, 8'h05);
    hold(TICK);
    rc(8'hA2, 8'h7F);
    warm();
    rc(8'hA2, 8'h7F);
    chk({7'h00, time_running}, 8'h01);
    hold(TICK);
    rc(8'hA2, 8'h00);
    rc(8'hA3, 8'h00);
    rc(8'hA4, 8'h00);
    rc(8'hA5, 8'h00);
  endtask : s_roll

  // Each timebase counts one carry into its own register
  task automatic s_base;
    for (int k = 0; k < 4; k++)
    begin
      ctl(8'h40);
      hold(20);
      wr(8'hA2, 8'h7F);
      wr(8'hA3, (k > 0) ? 8'h3B : 8'h00);
      wr(8'hA4, (k > 1) ? 8'h3B : 8'h00);
      wr(8'hA5, (k > 2) ? 8'h17 : 8'h00);
      ctl(8'h43 | 8'(k << 4));
      hold(TICK);
      rc(rtc_pkg::ADDR_INT_COUNT, 8'h01);
    end
    ctl(8'h41);
    hold(20);
    rc(rtc_pkg::ADDR_INT_COUNT, 8'h00);
  endtask : s_base

  // Periodic timeouts, masking, sticky flag, then single shot
  task automatic s_irq;
    ctl(8'h40);
    hold(20);
    wr(8'hA6, 8'h01);
    irq_en <= 1'b1;
    ctl(8'h43);
    hold(TICK);
    rc(rtc_pkg::ADDR_CONTROL, 8'h47);
    rc(rtc_pkg::ADDR_INT_COUNT, 8'h00);
    chk({7'h00, interval_irq}, 8'h01);
    @(posedge clk_sys);
    irq_en <= 1'b0;
    hold(2);
    #1 chk({7'h00, interval_irq}, 8'h00);
    hold(TICK);
    rc(rtc_pkg::ADDR_CONTROL, 8'h47);
    ctl(8'h43);
    rc(rtc_pkg::ADDR_CONTROL, 8'h43);
    ctl(8'h4B);
    hold(TICK);
    rc(rtc_pkg::ADDR_CONTROL, 8'h4D);
    // Two periodic timeouts, then exactly one single shot
    hold(TICK);
    chk(timeouts, 8'h03);
  endtask : s_irq

  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    s_reset();
    s_clear();
    s_roll();
    s_base();
    s_irq();
    end_sim();
  end
endmodule : interval_timer_rtc_test
